// >>> core/jthc_pkg.sv
package jthc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // opcode matching
  localparam logic [15:0] OP_HALT       = 16'h0080;
  localparam logic [13:0] OP_TRAP_HI    = 14'h0120;
  localparam logic [15:0] OP_JREG_MASK  = 16'hfef0;
  // bit 8 is the delay bit and is masked off, so the pattern must keep it clear
  localparam logic [15:0] OP_JREG       = 16'h0280;
  localparam logic [6:0]  OP_JREL_HI    = 7'h0f;
  localparam logic [6:0]  OP_JEQ_HI     = 7'h0c;
  localparam logic [2:0]  OP_EXT_HI     = 3'h6;
  localparam int          DELAY_BIT     = 8;

  //////////////////////////////////////////////////////////////////////////////
  // trap table and stack
  localparam logic [31:0] TRAP_BASE_INT = 32'h0008_0000;
  localparam logic [31:0] TRAP_BASE_EXT = 32'h00c0_0000;
  localparam logic [31:0] TRAP_VEC_OFS  = 32'h0000_0030;
  localparam logic [31:0] SP_STEP       = 32'h0000_0004;
  localparam logic [31:0] RET_STEP      = 32'h0000_0002;

  //////////////////////////////////////////////////////////////////////////////
  // cycle counts of the software exception sequence
  localparam logic [3:0]  TRAP_CYCLES    = 4'ha;
  localparam logic [3:0]  TRAP_CNT_PSR   = TRAP_CYCLES - 4'h1;
  localparam logic [3:0]  TRAP_CNT_READ  = TRAP_CYCLES - 4'h2;
  localparam logic [3:0]  TRAP_CNT_CATCH = TRAP_CYCLES - 4'h4;
  localparam logic [3:0]  TRAP_CNT_LAST  = 4'h1;

  //////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [31:0] REG_CTRL      = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS    = 32'h0000_0004;
  localparam logic [31:0] REG_TARGET    = 32'h0000_0008;
  localparam int          CTRL_WAKE_BIT = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    JTHC_K_OTHER, JTHC_K_HALT, JTHC_K_TRAP, JTHC_K_JREG, JTHC_K_JREL, JTHC_K_JEQ, JTHC_K_EXT
  } jthc_kind_t;

  typedef enum logic [1:0] {JTHC_IDLE, JTHC_BUSY, JTHC_TRAP, JTHC_HALTED} jthc_state_t;

endpackage : jthc_pkg

// >>> core/jthc_if.sv
`timescale 1ns/1ns

interface jthc_dec_if;
  import jthc_pkg::*;
  logic [15:0] instr;
  logic [1:0]  ext_cnt;
  logic [12:0] ext_first;
  logic [12:0] ext_last;
  jthc_kind_t  kind;
  logic        delayed;
  logic [31:0] disp;
  logic [3:0]  reg_sel;
  logic [1:0]  trap_num;
  modport dec  (input instr, ext_cnt, ext_first, ext_last,
                output kind, delayed, disp, reg_sel, trap_num);
  modport core (output instr, ext_cnt, ext_first, ext_last,
                input kind, delayed, disp, reg_sel, trap_num);
endinterface : jthc_dec_if

interface jthc_reg_if;
  logic        wake;
  logic [31:0] status;
  logic [31:0] last_target;
  modport slave (output wake, input status, last_target);
  modport core  (input wake, output status, last_target);
endinterface : jthc_reg_if

// >>> core/jthc_decode.sv
`timescale 1ns/1ns

module jthc_decode
  import jthc_pkg::*;
(
  jthc_dec_if.dec d
);

  logic [7:0] short_displacement;

  assign short_displacement = d.instr[7:0];
  assign d.reg_sel          = d.instr[3:0];
  assign d.trap_num         = d.instr[1:0];

  always_comb begin
    d.kind    = JTHC_K_OTHER;
    d.delayed = 1'b0;
    if (d.instr == OP_HALT) begin
      d.kind = JTHC_K_HALT;
    end else if (d.instr[15:2] == OP_TRAP_HI) begin
      d.kind = JTHC_K_TRAP;
    end else if ((d.instr & OP_JREG_MASK) == OP_JREG) begin
      d.kind    = JTHC_K_JREG;
      d.delayed = d.instr[DELAY_BIT];
    end else if (d.instr[15:9] == OP_JREL_HI) begin
      d.kind    = JTHC_K_JREL;
      d.delayed = d.instr[DELAY_BIT];
    end else if (d.instr[15:9] == OP_JEQ_HI) begin
      d.kind    = JTHC_K_JEQ;
      d.delayed = d.instr[DELAY_BIT];
    end else if (d.instr[15:13] == OP_EXT_HI) begin
      d.kind = JTHC_K_EXT;
    end
  end

  // displacement is always even; prefixes stack on the high side
  always_comb begin
    case (d.ext_cnt)
      2'd0: begin
        d.disp = {{23{short_displacement[7]}}, short_displacement, 1'b0};
      end
      2'd1: begin
        d.disp = {{10{d.ext_first[12]}}, d.ext_first, short_displacement, 1'b0};
      end
      default: begin
        // low three bits of the first prefix are dropped
        d.disp = {d.ext_first[12:3], d.ext_last, short_displacement, 1'b0};
      end
    endcase
  end

endmodule : jthc_decode

// >>> core/jthc_axil.sv
`timescale 1ns/1ns

module jthc_axil
  import jthc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  jthc_reg_if.slave        r
);

  typedef struct packed {
    logic        aw_held;
    logic        w_held;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        wake;
  } jthc_axil_state_t;

  jthc_axil_state_t s;
  jthc_axil_state_t next_s;

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready  = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign r.wake        = s.wake;

  always_comb begin
    next_s      = s;
    next_s.wake = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    // status and target are read-only: writes to them are accepted and dropped
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (s.waddr == REG_CTRL) begin
        next_s.wake = s.wstrb0 && s.wdata[CTRL_WAKE_BIT];
      end else if (s.waddr != REG_STATUS && s.waddr != REG_TARGET) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:   next_s.rdata = 32'h0000_0000;
        REG_STATUS: next_s.rdata = r.status;
        REG_TARGET: next_s.rdata = r.last_target;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : jthc_axil

// >>> core/jthc_core.sv
`timescale 1ns/1ns
// Contract
// - halt: one cycle, then stop executing
// - interrupt ends halt; resume after halt
// - trap pushes pc plus 2, then status
// - trap loads vector into pc; ten cycles
// - two-bit field picks trap 0 to 3
// - trap 0 at base+48, 3 at base+60
// - base chosen by boot area select input
// - register jump clears bit 0; two cycles
// - delay bit runs next instruction first
// - traps masked between jump and slot
// - short relative jump: pc plus 2*disp
// - one prefix gives 22-bit displacement
// - two prefixes give full 32-bit displacement
// - equal jump only when zero flag set
// - false condition continues sequentially
// - traps masked during prefix and target
// - only first and last prefixes count

module jthc_core
  import jthc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        instr_valid,
  output      logic        instr_ready,
  input  wire logic [15:0] instr,
  input  wire logic [31:0] instr_pc,
  input  wire logic        zero_flag,
  input  wire logic [31:0] stack_pointer,
  input  wire logic [31:0] status_word,
  output      logic [3:0]  jump_target_register,
  input  wire logic [31:0] target_reg_data,
  input  wire logic        irq_req,
  input  wire logic        boot_area_select,
  output      logic        pc_load,
  output      logic [31:0] pc_value,
  output      logic        sp_load,
  output      logic [31:0] sp_value,
  output      logic        mem_req,
  output      logic        mem_we,
  output      logic [31:0] mem_addr,
  output      logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  output      logic        halted,
  output      logic        halt_wake,
  output      logic        trap_mask,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef struct packed {
    jthc_state_t st;
    logic [3:0]  cnt;
    logic [1:0]  ext_cnt;
    logic [12:0] ext_first;
    logic [12:0] ext_last;
    logic        tgt_run;
    logic        dly;
    logic        dly_take;
    logic [31:0] tgt;
    logic [31:0] vec;
    logic [31:0] sp;
    logic [31:0] psr;
    logic        pc_load;
    logic [31:0] pc_value;
    logic        sp_load;
    logic [31:0] sp_value;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        wake;
    logic [31:0] last_tgt;
  } jthc_core_state_t;

  jthc_core_state_t s;
  jthc_core_state_t next_s;

  logic        acc;
  logic        taken;
  logic [31:0] target_c;
  logic [31:0] vec_c;
  logic [12:0] prefix_immediate;

  jthc_dec_if dec ();
  jthc_reg_if regs ();

  //////////////////////////////////////////////////////////////////////////////
  // decode and register access

  assign dec.instr     = instr;
  assign dec.ext_cnt   = s.ext_cnt;
  assign dec.ext_first = s.ext_first;
  assign dec.ext_last  = s.ext_last;

  jthc_decode u_decode (
    .d (dec.dec)
  );

  assign regs.status      = {26'h0, s.tgt_run, s.dly, s.ext_cnt, trap_mask, halted};
  assign regs.last_target = s.last_tgt;

  jthc_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .r             (regs.slave)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign instr_ready          = (s.st == JTHC_IDLE);
  assign acc                  = instr_valid && instr_ready;
  assign halted               = (s.st == JTHC_HALTED);
  assign trap_mask            = (s.ext_cnt != 2'd0) || s.tgt_run || s.dly;
  assign jump_target_register = dec.reg_sel;
  assign prefix_immediate     = instr[12:0];
  assign pc_load              = s.pc_load;
  assign pc_value             = s.pc_value;
  assign sp_load              = s.sp_load;
  assign sp_value             = s.sp_value;
  assign mem_req              = s.mem_req;
  assign mem_we               = s.mem_we;
  assign mem_addr             = s.mem_addr;
  assign mem_wdata            = s.mem_wdata;
  assign halt_wake            = s.wake;

  assign taken = (dec.kind == JTHC_K_JREG) || (dec.kind == JTHC_K_JREL)
              || (dec.kind == JTHC_K_JEQ && zero_flag);
  assign target_c = (dec.kind == JTHC_K_JREG) ? {target_reg_data[31:1], 1'b0}
                                              : instr_pc + dec.disp;
  assign vec_c = (boot_area_select ? TRAP_BASE_INT : TRAP_BASE_EXT)
               + TRAP_VEC_OFS + {28'h0, dec.trap_num, 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_s         = s;
    next_s.pc_load = 1'b0;
    next_s.sp_load = 1'b0;
    next_s.mem_req = 1'b0;
    next_s.mem_we  = 1'b0;
    next_s.wake    = 1'b0;
    case (s.st)
      JTHC_IDLE: if (acc) begin
        // the slot instruction retires now, so the delayed branch lands
        if (s.dly) begin
          next_s.dly = 1'b0;
          if (s.dly_take) begin
            next_s.pc_load  = 1'b1;
            next_s.pc_value = s.tgt;
            next_s.last_tgt = s.tgt;
          end
        end
        if (dec.kind == JTHC_K_EXT) begin
          case (s.ext_cnt)
            2'd0: begin
              next_s.ext_first = prefix_immediate;
              next_s.ext_cnt   = 2'd1;
            end
            default: begin
              // a third prefix replaces the second; the first always stays
              next_s.ext_last = prefix_immediate;
              next_s.ext_cnt  = 2'd2;
            end
          endcase
        end else begin
          next_s.ext_cnt = 2'd0;
        end
        case (dec.kind)
          JTHC_K_HALT: next_s.st = JTHC_HALTED;
          JTHC_K_TRAP: begin
            next_s.st        = JTHC_TRAP;
            next_s.cnt       = TRAP_CNT_PSR;
            next_s.sp        = stack_pointer;
            next_s.psr       = status_word;
            next_s.vec       = vec_c;
            next_s.mem_req   = 1'b1;
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = stack_pointer - SP_STEP;
            next_s.mem_wdata = instr_pc + RET_STEP;
          end
          JTHC_K_JREG, JTHC_K_JREL, JTHC_K_JEQ: begin
            next_s.tgt = target_c;
            if (dec.delayed) begin
              next_s.dly      = 1'b1;
              next_s.dly_take = taken;
            end else if (taken) begin
              next_s.st = JTHC_BUSY;
            end
          end
          default: ;
        endcase
        // a prefixed target that spans cycles keeps traps masked until done
        next_s.tgt_run = (s.ext_cnt != 2'd0) && (next_s.st != JTHC_IDLE);
      end
      JTHC_BUSY: begin
        next_s.st       = JTHC_IDLE;
        next_s.tgt_run  = 1'b0;
        next_s.pc_load  = 1'b1;
        next_s.pc_value = s.tgt;
        next_s.last_tgt = s.tgt;
      end
      JTHC_TRAP: begin
        next_s.cnt = s.cnt - 4'h1;
        case (s.cnt)
          TRAP_CNT_PSR: begin
            next_s.mem_req   = 1'b1;
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = s.sp - SP_STEP - SP_STEP;
            next_s.mem_wdata = s.psr;
          end
          TRAP_CNT_READ: begin
            next_s.mem_req  = 1'b1;
            next_s.mem_addr = s.vec;
          end
          // memory answers one cycle after the read request is shown
          TRAP_CNT_CATCH: next_s.tgt = mem_rdata;
          TRAP_CNT_LAST: begin
            next_s.st       = JTHC_IDLE;
            next_s.tgt_run  = 1'b0;
            next_s.pc_load  = 1'b1;
            next_s.pc_value = s.tgt;
            next_s.last_tgt = s.tgt;
            next_s.sp_load  = 1'b1;
            next_s.sp_value = s.sp - SP_STEP - SP_STEP;
          end
          default: ;
        endcase
      end
      JTHC_HALTED: begin
        // the interrupt logic outside saves the pc of the next instruction
        if (irq_req || regs.wake) begin
          next_s.st   = JTHC_IDLE;
          next_s.wake = 1'b1;
        end
      end
      default: next_s.st = JTHC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  halt_enter_a: assert property (
    acc && dec.kind == JTHC_K_HALT |=> halted && !instr_ready [*2])
    else $error("halt did not stop execution");

  halt_wake_a: assert property (
    halted && irq_req |=> halt_wake && instr_ready && !halted)
    else $error("interrupt did not end halt");

  trap_push_a: assert property (
    acc && dec.kind == JTHC_K_TRAP |=>
      mem_we && mem_addr == $past(stack_pointer) - SP_STEP
      && mem_wdata == $past(instr_pc) + RET_STEP
      ##1 mem_we && mem_addr == $past(stack_pointer, 2) - SP_STEP - SP_STEP
      && mem_wdata == $past(status_word, 2))
    else $error("trap stack pushes wrong");

  trap_len_a: assert property (
    acc && dec.kind == JTHC_K_TRAP |=>
      !instr_ready [*8] ##1 !instr_ready ##1 instr_ready && pc_load && sp_load)
    else $error("trap did not take ten cycles");

  trap_vec_a: assert property (
    acc && dec.kind == JTHC_K_TRAP |-> ##3 mem_req && !mem_we
      && mem_addr == ($past(boot_area_select, 3) ? TRAP_BASE_INT : TRAP_BASE_EXT)
         + TRAP_VEC_OFS + {28'h0, $past(instr[1:0], 3), 2'b00})
    else $error("trap vector address wrong");

  reg_jump_a: assert property (
    acc && dec.kind == JTHC_K_JREG && !dec.delayed |=>
      !instr_ready ##1 pc_load && pc_value == {$past(target_reg_data[31:1], 2), 1'b0})
    else $error("register jump target wrong");

  delay_mask_a: assert property (
    acc && !s.dly && dec.delayed && dec.kind != JTHC_K_OTHER |=>
      instr_ready && trap_mask && !pc_load)
    else $error("delayed jump not masked");

  slot_land_a: assert property (
    acc && s.dly && s.dly_take |=> pc_load && pc_value == $past(s.tgt))
    else $error("delayed branch lost");

  far_disp_a: assert property (
    acc && dec.kind == JTHC_K_JREL && !dec.delayed && s.ext_cnt == 2'd2 |-> ##2
      pc_value == $past(instr_pc, 2)
      + {$past(s.ext_first[12:3], 2), $past(s.ext_last, 2), $past(instr[7:0], 2), 1'b0})
    else $error("two-prefix displacement wrong");

  short_disp_a: assert property (
    acc && dec.kind == JTHC_K_JREL && !dec.delayed && s.ext_cnt == 2'd0 |-> ##2
      pc_load && pc_value == $past(instr_pc, 2)
      + {{23{$past(instr[7], 2)}}, $past(instr[7:0], 2), 1'b0})
    else $error("short displacement wrong");

  eq_skip_a: assert property (
    acc && dec.kind == JTHC_K_JEQ && !dec.delayed && !zero_flag |=> instr_ready && !pc_load)
    else $error("equal jump taken on clear zero flag");

  ext_mask_a: assert property (
    acc && dec.kind == JTHC_K_EXT |=> trap_mask)
    else $error("prefix did not mask traps");

  halt_wake_c: cover property (halted ##1 halt_wake);
  trap_done_c: cover property (s.st == JTHC_TRAP && s.cnt == TRAP_CNT_LAST ##1 pc_load);
  slot_land_c: cover property (acc && s.dly && s.dly_take);
  far_jump_c:  cover property (acc && dec.kind == JTHC_K_JREL && s.ext_cnt == 2'd2);

endmodule : jthc_core

// >>> bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import jthc_pkg::*;
  logic        aclk, aresetn, instr_valid, instr_ready, zero_flag, irq_req, boot_area_select;
  logic        pc_load, sp_load, mem_req, mem_we, halted, halt_wake, trap_mask, dl, z;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  jump_target_register, s_axi_wstrb;
  logic [7:0]  d8;
  logic [12:0] ea, eb;
  logic [15:0] instr;
  logic [31:0] instr_pc, stack_pointer, status_word, target_reg_data, mem_rdata, pc_value;
  logic [31:0] sp_value, mem_addr, mem_wdata, s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [31:0] s_axi_rdata, seed, x, exp, tgt;
  logic [31:0] wa[$], wd[$];
  int          mismatches = 0, compares = 0, cycles = 0, n, k, c;

  jthc_core i_jthc_core (.aclk, .aresetn, .instr_valid, .instr_ready, .instr, .instr_pc,
    .zero_flag, .stack_pointer, .status_word, .jump_target_register, .target_reg_data,
    .irq_req, .boot_area_select, .pc_load, .pc_value, .sp_load, .sp_value, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .halted, .halt_wake, .trap_mask, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // vector word is a function of its address so a wrong table slot shows up
  function automatic logic [31:0] vec(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : vec

  function automatic logic [31:0] disp(input int c, input logic [12:0] a, b,
                                       input logic [7:0] d);
    if (c == 0) return {{23{d[7]}}, d, 1'b0};
    if (c == 1) return {{10{a[12]}}, a, d, 1'b0};
    return {a[12:3], b, d, 1'b0};
  endfunction : disp

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test();
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // memory answers reads one cycle later; otherwise the data lines churn
  always @(posedge aclk) begin
    if (mem_req && mem_we) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    mem_rdata <= (mem_req && !mem_we) ? vec(mem_addr) : rnd();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [15:0] op, input logic [31:0] pc, input logic zf);
    @(posedge aclk);
    instr_valid <= 1;
    instr <= op;
    instr_pc <= pc;
    zero_flag <= zf;
    target_reg_data <= rnd();
    stack_pointer <= rnd() & ~3;
    status_word <= rnd();
    n = 0;
    do begin @(negedge aclk); n++; end while (instr_ready !== 1 && n < 50);
    @(posedge aclk);
    instr_valid <= 0;
  endtask : issue

  task automatic wait_pc(input int lim);
    n = 0;
    do begin @(negedge aclk); n++; end while (pc_load !== 1 && n < lim);
  endtask : wait_pc

  task automatic axi(input logic we, input logic [31:0] a, d, input logic [1:0] r);
    logic aw, w, ar, b;
    logic [31:0] got;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      aw = s_axi_awready;
      w = s_axi_wready;
      ar = s_axi_arready;
      b = we ? (s_axi_bvalid === 1) : (s_axi_rvalid === 1);
      got = s_axi_rdata;
      rs = we ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (aw === 1) s_axi_awvalid <= 0;
      if (w === 1) s_axi_wvalid <= 0;
      if (ar === 1) s_axi_arvalid <= 0;
    end while (!b && n < 50);
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    check(rs, r);
    if (!we) check(got, d);
  endtask : axi

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'd7646;
    {aresetn, instr_valid, zero_flag, irq_req, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, instr, instr_pc, stack_pointer} = '0;
    {status_word, target_reg_data, mem_rdata, s_axi_awaddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_araddr, ea, eb, tgt} = '0;
    boot_area_select = 1;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    axi(0, REG_STATUS, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      boot_area_select <= i[2];
      wa.delete();
      wd.delete();
      issue({OP_TRAP_HI, i[1:0]}, rnd() & ~1, 0);
      wait_pc(20);
      check(n, 10);
      check(pc_value, vec((i[2] ? TRAP_BASE_INT : TRAP_BASE_EXT) + 48 + 4 * i[1:0]));
      check(sp_load, 1);
      check(sp_value, stack_pointer - 8);
      check(wa[0], stack_pointer - 4);
      check(wd[0], instr_pc + 2);
      check(wa[1], stack_pointer - 8);
      check(wd[1], status_word);
    end
    for (int i = 0; i < 40; i++) begin
      x = rnd();
      k = (i < 4) ? 3 : x[1:0];
      c = (k == 3) ? ((i < 4) ? i : x[3:2]) : 0;
      d8 = (i == 0) ? 8'h80 : x[11:4];
      dl = x[12];
      z = x[13];
      for (int p = 0; p < c; p++) begin
        x = rnd();
        if (p == 0) ea = x[12:0];
        else eb = x[12:0];
        issue({OP_EXT_HI, x[12:0]}, rnd() & ~1, 0);
        @(negedge aclk);
        check(trap_mask, 1);
      end
      x = rnd() & ~1;
      case (k)
        0: issue({OP_JREG[15:9], dl, OP_JREG[7:4], x[3:1], 1'b1}, x, z);
        2: issue({OP_JEQ_HI, dl, d8}, x, z);
        default: issue({OP_JREL_HI, dl, d8}, x, z);
      endcase
      if (k == 0) check(jump_target_register, instr[3:0]);
      exp = (k == 0) ? (target_reg_data & ~1) : instr_pc + disp(c > 2 ? 2 : c, ea, eb, d8);
      if (dl) begin
        @(negedge aclk);
        check(trap_mask, 1);
        issue(16'h0000, instr_pc + 2, 0);
      end
      wait_pc(3);
      if (k == 2 && !z) check(pc_load, 0);
      else check(n, dl ? 1 : 2);
      if (k != 2 || z) check(pc_value, exp);
      if (k != 2 || z) tgt = exp;
    end
    axi(0, REG_TARGET, tgt, RESP_OKAY);
    issue(OP_HALT, rnd() & ~1, 0);
    @(negedge aclk);
    check({halted, instr_ready}, 2'b10);
    @(posedge aclk);
    irq_req <= 1;
    @(posedge aclk);
    irq_req <= 0;
    @(negedge aclk);
    check({halt_wake, halted}, 2'b10);
    issue(OP_HALT, rnd() & ~1, 0);
    axi(0, REG_STATUS, 32'h0000_0001, RESP_OKAY);
    axi(1, REG_CTRL, 32'h0000_0001, RESP_OKAY);
    // the wake pulse has passed by the time the write answer is taken
    axi(0, REG_STATUS, 32'h0000_0000, RESP_OKAY);
    check(halted, 0);
    axi(1, REG_STATUS, 32'h0000_00ff, RESP_OKAY);
    axi(1, 32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
    axi(0, 32'h0000_000c, 32'h0000_0000, RESP_SLVERR);
    stop_test();
  end
endmodule : testbench
